// ---- ief_pkg.sv ----
package ief_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int IEF_AW = 12;
    localparam int IEF_DW = 32;
    localparam int IEF_NPORT = 24;
    localparam int IEF_DMA_BIT = 31;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] IEF_OFF_BUF_STS = 12'h484;
    localparam logic [11:0] IEF_OFF_PORT_STS = 12'h488;
    localparam logic [11:0] IEF_OFF_BUF_IEN = 12'h490;
    localparam logic [11:0] IEF_OFF_PORT_IEN = 12'h494;
    localparam logic [31:0] IEF_RST_VAL = 32'h0000_0000;
    localparam logic [23:0] IEF_PORT_RST = 24'h00_0000;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] IEF_RESP_OKAY = 2'h0;
    localparam logic [1:0] IEF_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } ief_wr_t;

    typedef enum logic [1:0] {
        IEF_ST_IDLE,
        IEF_ST_WORK,
        IEF_ST_RESP
    } ief_st_t;
endpackage

// ---- ief_sticky_bank.sv ----
`timescale 1ns/100ps
module ief_sticky_bank #(
    parameter int W = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_flag_q
);
    // ------------------------------------------------------------
    // one write-one-to-clear flag per bit, set beats clear
    // ------------------------------------------------------------
    genvar g;
    for (g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                o_flag_q[g] <= 1'b0;
            end else if (i_set[g]) begin
                o_flag_q[g] <= 1'b1;
            end else if (i_clr[g]) begin
                o_flag_q[g] <= 1'b0;
            end
        end
    end
endmodule

// ---- ief_axil_slave.sv ----
`timescale 1ns/100ps
module ief_axil_slave
    import ief_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [11:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [11:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output ief_wr_t o_wr,
    output logic o_wr_vld,
    input wire logic i_wr_hit,
    output logic [11:0] o_rd_addr,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_hit
);
    ief_st_t wr_st_q;
    ief_st_t rd_st_q;
    logic aw_have_q;
    logic w_have_q;

    // ------------------------------------------------------------
    // write path: address and data in either order
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_st_q <= IEF_ST_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_wr_vld <= 1'b0;
            o_wr <= '0;
            o_bvalid <= 1'b0;
            o_bresp <= IEF_RESP_OKAY;
        end else begin
            case (wr_st_q)
                IEF_ST_IDLE: begin
                    if (i_awvalid && o_awready) begin
                        aw_have_q <= 1'b1;
                        o_awready <= 1'b0;
                        o_wr.addr <= i_awaddr;
                    end else if (!aw_have_q) begin
                        o_awready <= 1'b1;
                    end
                    if (i_wvalid && o_wready) begin
                        w_have_q <= 1'b1;
                        o_wready <= 1'b0;
                        o_wr.data <= i_wdata;
                        o_wr.strb <= i_wstrb;
                    end else if (!w_have_q) begin
                        o_wready <= 1'b1;
                    end
                    if (aw_have_q && w_have_q) begin
                        aw_have_q <= 1'b0;
                        w_have_q <= 1'b0;
                        o_wr_vld <= 1'b1;
                        wr_st_q <= IEF_ST_WORK;
                    end
                end
                IEF_ST_WORK: begin
                    o_wr_vld <= 1'b0;
                    o_bvalid <= 1'b1;
                    o_bresp <= i_wr_hit ? IEF_RESP_OKAY : IEF_RESP_SLVERR;
                    wr_st_q <= IEF_ST_RESP;
                end
                IEF_ST_RESP: begin
                    if (i_bready) begin
                        o_bvalid <= 1'b0;
                        wr_st_q <= IEF_ST_IDLE;
                    end
                end
                default: begin
                    wr_st_q <= IEF_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rd_st_q <= IEF_ST_IDLE;
            o_arready <= 1'b0;
            o_rd_addr <= 12'h000;
            o_rvalid <= 1'b0;
            o_rdata <= IEF_RST_VAL;
            o_rresp <= IEF_RESP_OKAY;
        end else begin
            case (rd_st_q)
                IEF_ST_IDLE: begin
                    if (i_arvalid && o_arready) begin
                        o_arready <= 1'b0;
                        o_rd_addr <= i_araddr;
                        rd_st_q <= IEF_ST_WORK;
                    end else begin
                        o_arready <= 1'b1;
                    end
                end
                IEF_ST_WORK: begin
                    o_rvalid <= 1'b1;
                    o_rdata <= i_rd_data;
                    o_rresp <= i_rd_hit ? IEF_RESP_OKAY : IEF_RESP_SLVERR;
                    rd_st_q <= IEF_ST_RESP;
                end
                IEF_ST_RESP: begin
                    if (i_rready) begin
                        o_rvalid <= 1'b0;
                        rd_st_q <= IEF_ST_IDLE;
                    end
                end
                default: begin
                    rd_st_q <= IEF_ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- ief_top.sv ----
`timescale 1ns/100ps
module ief_top
    import ief_pkg::*;
#(
    parameter bit P_HAS_DMA = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_soft_rst_n,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [11:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [11:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic [23:0] i_port_aer_err,
    input wire logic [23:0] i_port_error_report_mask,
    input wire logic i_dma_parity_err,
    output logic [23:0] o_port_flags,
    output logic o_dma_path_parity_flag,
    output logic o_irq
);
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic bus_rst_n;
    ief_wr_t wr;
    logic wr_vld;
    logic wr_hit;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [31:0] lane;
    logic wr_buf_sts;
    logic wr_port_sts;
    logic wr_buf_ien;
    logic wr_port_ien;
    logic [23:0] set_ports;
    logic [23:0] clr_ports;
    logic set_dma;
    logic clr_dma;
    logic [23:0] port_ien_q;
    logic dma_ien_q;

    // soft reset clears the bus and enables only
    assign bus_rst_n = i_rst_n & i_soft_rst_n;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    ief_axil_slave u_bus (
        .i_mclk(i_mclk),
        .i_rst_n(bus_rst_n),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_wr(wr),
        .o_wr_vld(wr_vld),
        .i_wr_hit(wr_hit),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .i_rd_hit(rd_hit)
    );

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    assign lane = {{8{wr.strb[3]}}, {8{wr.strb[2]}},
                   {8{wr.strb[1]}}, {8{wr.strb[0]}}};
    assign wr_buf_sts = wr_vld && (wr.addr[11:2] == IEF_OFF_BUF_STS[11:2]);
    assign wr_port_sts = wr_vld && (wr.addr[11:2] == IEF_OFF_PORT_STS[11:2]);
    assign wr_buf_ien = wr_vld && (wr.addr[11:2] == IEF_OFF_BUF_IEN[11:2]);
    assign wr_port_ien = wr_vld && (wr.addr[11:2] == IEF_OFF_PORT_IEN[11:2]);
    assign wr_hit = wr_buf_sts | wr_port_sts | wr_buf_ien | wr_port_ien;

    // ------------------------------------------------------------
    // flag set and clear terms
    // ------------------------------------------------------------
    // port event sets flag unless its bit in i_port_error_report_mask is set
    assign set_ports = i_port_aer_err & ~i_port_error_report_mask;
    assign clr_ports = wr_port_sts ? (wr.data[23:0] & lane[23:0]) : IEF_PORT_RST;
    assign set_dma = i_dma_parity_err & P_HAS_DMA;
    assign clr_dma = wr_buf_sts & wr.data[IEF_DMA_BIT] & lane[IEF_DMA_BIT];

    // ------------------------------------------------------------
    // sticky flags, power-on reset only
    // ------------------------------------------------------------
    // bit n holds port n
    ief_sticky_bank #(
        .W(IEF_NPORT)
    ) u_port_flags (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_set(set_ports),
        .i_clr(clr_ports),
        .o_flag_q(o_port_flags)
    );

    ief_sticky_bank #(
        .W(1)
    ) u_dma_flag (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_set(set_dma),
        .i_clr(clr_dma),
        .o_flag_q(o_dma_path_parity_flag)
    );

    // ------------------------------------------------------------
    // interrupt enables
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!bus_rst_n) begin
            port_ien_q <= IEF_PORT_RST;
        end else if (wr_port_ien) begin
            port_ien_q <= (port_ien_q & ~lane[23:0]) | (wr.data[23:0] & lane[23:0]);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!bus_rst_n) begin
            dma_ien_q <= 1'b0;
        end else if (wr_buf_ien && lane[IEF_DMA_BIT]) begin
            dma_ien_q <= wr.data[IEF_DMA_BIT] & P_HAS_DMA;
        end
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (|(o_port_flags & port_ien_q)) | (o_dma_path_parity_flag & dma_ien_q);
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // reserved bits read zero
    always_comb begin
        rd_data = IEF_RST_VAL;
        rd_hit = 1'b1;
        case (rd_addr[11:2])
            IEF_OFF_BUF_STS[11:2]: begin
                rd_data[IEF_DMA_BIT] = o_dma_path_parity_flag;
            end
            IEF_OFF_PORT_STS[11:2]: begin
                rd_data[23:0] = o_port_flags;
            end
            IEF_OFF_BUF_IEN[11:2]: begin
                rd_data[IEF_DMA_BIT] = dma_ien_q;
            end
            IEF_OFF_PORT_IEN[11:2]: begin
                rd_data[23:0] = port_ien_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_dma_set;
        @(posedge i_mclk) disable iff (!i_rst_n)
        set_dma |=> o_dma_path_parity_flag;
    endproperty
    a_dma_set: assert property (p_dma_set) else $error("dma flag not set");

    property p_dma_tied;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (P_HAS_DMA == 1'b0) |-> !o_dma_path_parity_flag && !dma_ien_q;
    endproperty
    a_dma_tied: assert property (p_dma_tied) else $error("dma flag set without dma");

    property p_port_read;
        @(posedge i_mclk) disable iff (!bus_rst_n)
        $rose(o_rvalid) && $past(rd_addr) == IEF_OFF_PORT_STS
        |-> o_rdata == {8'h00, $past(o_port_flags)};
    endproperty
    a_port_read: assert property (p_port_read) else $error("port status read wrong");

    property p_port_set;
        @(posedge i_mclk) disable iff (!i_rst_n)
        set_ports != 24'h0 |=> (o_port_flags & $past(set_ports)) == $past(set_ports);
    endproperty
    a_port_set: assert property (p_port_set) else $error("port flag not set");

    property p_port_masked;
        @(posedge i_mclk) disable iff (!i_rst_n)
        1'b1 |=> (o_port_flags & ~$past(o_port_flags) & ~$past(set_ports)) == 24'h0;
    endproperty
    a_port_masked: assert property (p_port_masked) else $error("flag set by masked event");

    property p_no_fall;
        @(posedge i_mclk) disable iff (!i_rst_n)
        1'b1 |=> ($past(o_port_flags) & ~o_port_flags & ~$past(clr_ports)) == 24'h0;
    endproperty
    a_no_fall: assert property (p_no_fall) else $error("flag lost without clear");

    property p_clear;
        @(posedge i_mclk) disable iff (!i_rst_n)
        wr_port_sts |=> (o_port_flags & $past(clr_ports) & ~$past(set_ports)) == 24'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear");

    property p_dma_clear;
        @(posedge i_mclk) disable iff (!i_rst_n)
        clr_dma && !set_dma |=> !o_dma_path_parity_flag;
    endproperty
    a_dma_clear: assert property (p_dma_clear) else $error("dma flag not cleared");

    property p_wr_answer;
        @(posedge i_mclk) disable iff (!bus_rst_n)
        wr_vld |=> o_bvalid && o_bresp == (($past(wr_hit)) ? IEF_RESP_OKAY : IEF_RESP_SLVERR);
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer wrong");

    property p_irq;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (o_port_flags & port_ien_q) != 24'h0 |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_dma_irq;
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_dma_path_parity_flag && dma_ien_q |=> o_irq;
    endproperty
    a_dma_irq: assert property (p_dma_irq) else $error("dma interrupt not raised");

    property p_irq_low;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (o_port_flags & port_ien_q) == 24'h0 && !(o_dma_path_parity_flag && dma_ien_q)
        |=> !o_irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt without enabled flag");

    property p_reserved_read;
        @(posedge i_mclk) disable iff (!bus_rst_n)
        o_rvalid |-> o_rdata[IEF_DMA_BIT-1:IEF_NPORT] == 7'h00;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved bits set");

    property p_wr_busy;
        @(posedge i_mclk) disable iff (!bus_rst_n)
        o_bvalid |-> !o_awready && !o_wready;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write taken while answer pending");

    property p_rd_busy;
        @(posedge i_mclk) disable iff (!bus_rst_n)
        o_rvalid |-> !o_arready;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read taken while answer pending");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_port_set: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_port_flags[23]));
    c_dma_set: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_dma_path_parity_flag));
    c_set_clr: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        (set_ports & clr_ports) != 24'h0);
    c_irq: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_irq));
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import ief_pkg::*;
    logic mclk, rst_n, srst_n, dma_err;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [23:0] aer, msk, flags;
    logic awready, wready, bvalid, arready, rvalid, dflag, dflag_b, irq;
    logic [1:0] bresp, rresp, resp;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    ief_top #(.P_HAS_DMA(1'b1)) u_ief_top (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_soft_rst_n(srst_n),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_port_aer_err(aer), .i_port_error_report_mask(msk), .i_dma_parity_err(dma_err),
        .o_port_flags(flags), .o_dma_path_parity_flag(dflag), .o_irq(irq)
    );

    // copy without the dma function, only its dma flag is watched
    ief_top #(.P_HAS_DMA(1'b0)) u_ief_top_nodma (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_soft_rst_n(srst_n),
        .i_awvalid(awvalid), .o_awready(), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(), .i_bready(bready), .o_bresp(),
        .i_arvalid(arvalid), .o_arready(), .i_araddr(araddr),
        .o_rvalid(), .i_rready(rready), .o_rdata(), .o_rresp(),
        .i_port_aer_err(aer), .i_port_error_report_mask(msk), .i_dma_parity_err(dma_err),
        .o_port_flags(), .o_dma_path_parity_flag(dflag_b), .o_irq()
    );

    // ----------------------------------------
    // clock, watchdog, verdict
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // tasks are entered just after a rising edge and return just after one
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 64);
        bready <= 1'b0;
        resp = bresp;
        if (n >= 64) chk(32'h0, 32'h1);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 64);
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
        if (n >= 64) chk(32'h0, 32'h1);
        chk(rd, e);
        chk({30'h0, resp}, {30'h0, er});
    endtask

    task automatic pulse(input logic [23:0] p, input logic d);
        @(posedge mclk);
        aer <= p;
        dma_err <= d;
        @(posedge mclk);
        aer <= 24'h00_0000;
        dma_err <= 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({7'h00, dflag, flags}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rchk(IEF_OFF_BUF_STS, 32'h0, IEF_RESP_OKAY);
        rchk(IEF_OFF_PORT_STS, 32'h0, IEF_RESP_OKAY);
        rchk(IEF_OFF_BUF_IEN, 32'h0, IEF_RESP_OKAY);
        rchk(IEF_OFF_PORT_IEN, 32'h0, IEF_RESP_OKAY);
    endtask

    task automatic t_ports();
        for (int n = 0; n < IEF_NPORT; n++) begin
            pulse(24'h00_0001 << n, 1'b0);
            @(posedge mclk);
            chk({8'h00, flags}, 32'h1 << n);
            wr(IEF_OFF_PORT_STS, 32'h0, 4'hF);
            chk({30'h0, resp}, {30'h0, IEF_RESP_OKAY});
            rchk(IEF_OFF_PORT_STS, 32'h1 << n, IEF_RESP_OKAY);
            wr(IEF_OFF_PORT_STS, 32'h1 << n, 4'hF);
            rchk(IEF_OFF_PORT_STS, 32'h0, IEF_RESP_OKAY);
        end
    endtask

    task automatic t_mask();
        msk <= 24'hAA_AAAA;
        pulse(24'hFF_FFFF, 1'b0);
        @(posedge mclk);
        chk({8'h00, flags}, 32'h0055_5555);
        msk <= 24'h00_0000;
        // only byte lane 0 is cleared
        wr(IEF_OFF_PORT_STS, 32'hFFFF_FFFF, 4'h1);
        rchk(IEF_OFF_PORT_STS, 32'h0055_5500, IEF_RESP_OKAY);
        wr(IEF_OFF_PORT_STS, 32'hFF00_0000, 4'hF);
        rchk(IEF_OFF_PORT_STS, 32'h0055_5500, IEF_RESP_OKAY);
        wr(IEF_OFF_PORT_STS, 32'h00FF_FFFF, 4'hF);
        // an event held through the clear keeps the flag set
        aer <= 24'h00_0008;
        wr(IEF_OFF_PORT_STS, 32'h0000_0008, 4'hF);
        aer <= 24'h00_0000;
        rchk(IEF_OFF_PORT_STS, 32'h0000_0008, IEF_RESP_OKAY);
        wr(IEF_OFF_PORT_STS, 32'h0000_0008, 4'hF);
        rchk(IEF_OFF_PORT_STS, 32'h0, IEF_RESP_OKAY);
    endtask

    task automatic t_dma();
        pulse(24'h00_0000, 1'b1);
        @(posedge mclk);
        chk({31'h0, dflag}, 32'h1);
        chk({31'h0, dflag_b}, 32'h0);
        wr(IEF_OFF_BUF_STS, 32'h7FFF_FFFF, 4'hF);
        rchk(IEF_OFF_BUF_STS, 32'h8000_0000, IEF_RESP_OKAY);
        wr(IEF_OFF_BUF_STS, 32'h8000_0000, 4'hF);
        rchk(IEF_OFF_BUF_STS, 32'h0, IEF_RESP_OKAY);
    endtask

    task automatic t_irq();
        wr(IEF_OFF_PORT_IEN, 32'h0000_0020, 4'hF);
        rchk(IEF_OFF_PORT_IEN, 32'h0000_0020, IEF_RESP_OKAY);
        pulse(24'h00_0020, 1'b0);
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        wr(IEF_OFF_PORT_IEN, 32'h0, 4'hF);
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        wr(IEF_OFF_BUF_IEN, 32'h8000_0000, 4'hF);
        rchk(IEF_OFF_BUF_IEN, 32'h8000_0000, IEF_RESP_OKAY);
        pulse(24'h00_0000, 1'b1);
        @(posedge mclk);
        @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        wr(IEF_OFF_BUF_STS, 32'h8000_0000, 4'hF);
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_soft();
        wr(IEF_OFF_PORT_IEN, 32'h0000_0020, 4'hF);
        @(posedge mclk);
        srst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        srst_n <= 1'b1;
        @(posedge mclk);
        chk({8'h00, flags}, 32'h0000_0020);
        rchk(IEF_OFF_PORT_IEN, 32'h0, IEF_RESP_OKAY);
        rchk(IEF_OFF_PORT_STS, 32'h0000_0020, IEF_RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(12'h4A0, 32'hFFFF_FFFF, 4'hF);
        chk({30'h0, resp}, {30'h0, IEF_RESP_SLVERR});
        rchk(12'h4A0, 32'h0, IEF_RESP_SLVERR);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk({8'h00, flags}, 32'h0);
    endtask

    initial begin
        rst_n = 1'b0;
        srst_n = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, dma_err} = 6'h00;
        {awaddr, araddr, wstrb} = 28'h000_0000;
        wdata = 32'h0;
        aer = 24'h00_0000;
        msk = 24'h00_0000;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_ports();
        t_mask();
        t_dma();
        t_irq();
        t_soft();
        end_of_test();
    end
endmodule
